// ### pkg/cmd_block_pkg.sv
// shared constants for the command block interpreter and its requester
package cmd_block_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;
    // command block word offsets
    localparam logic [7:0] OFF_LEN = 8'h00;
    localparam logic [7:0] OFF_WAIT = 8'h01;
    localparam logic [7:0] OFF_STYPE = 8'h02;
    localparam logic [7:0] OFF_SOFFS = 8'h03;
    localparam logic [7:0] OFF_IDLE = 8'h04;
    localparam logic [7:0] OFF_MAXT = 8'h05;
    localparam logic [7:0] OFF_CMD = 8'h06;
    localparam logic [7:0] OFF_OUTVAL = 8'h08;
    localparam logic [7:0] OFF_LAST = 8'h46;
    localparam int MAX_BLOCK_WORDS = 71;
    // status memory area codes
    localparam logic [7:0] MEM_DISC_IN = 8'h46;
    localparam logic [7:0] MEM_DISC_OUT = 8'h48;
    localparam logic [7:0] MEM_REGISTER = 8'h08;
    localparam logic [7:0] MEM_ANALOG_IN = 8'h0A;
    localparam logic [7:0] MEM_ANALOG_OUT = 8'h0C;
    // command numbers
    localparam logic [15:0] CMD_OUTPUTS = 16'h0008;
    localparam logic [15:0] CMD_DEQUEUE = 16'h000D;
    localparam logic [15:0] CMD_SEND = 16'h000E;
    localparam logic [15:0] CMD_REPLY_REQ = 16'h000F;
    // length limits, no-wait flag and outputs enable value
    localparam logic [15:0] LEN_OUTPUTS = 16'h0003;
    localparam logic [15:0] LEN_DEQUEUE = 16'h0007;
    localparam logic [15:0] LEN_SEND_MIN = 16'h0006;
    localparam logic [15:0] LEN_SEND_MAX = 16'h0046;
    localparam logic [15:0] LEN_REPLY_MIN = 16'h000A;
    localparam logic [15:0] LEN_REPLY_MAX = 16'h004E;
    localparam logic [15:0] WAIT_NOWAIT = 16'h0000;
    localparam logic [15:0] OUT_ENABLE = 16'h0001;
    // status words
    localparam logic [15:0] ST_BUSY = 16'h0001;
    localparam logic [15:0] ST_DONE = 16'h0004;
    localparam logic [15:0] ST_SYNTAX = 16'h0008;
    localparam logic [15:0] ST_DATA_ERR = 16'h0010;
    localparam logic [15:0] ST_NONE = 16'h0000;
    localparam logic [15:0] STX_BAD_LEN = 16'h00CA;
    localparam logic [15:0] STX_BAD_PTR = 16'h00CD;
    localparam logic [15:0] STX_BAD_CMD = 16'h00CE;
endpackage

// ### pkg/comm_request_if.sv
// shared-memory link between requester and interpreter
`timescale 1ns/1ps
interface comm_request_if;
    logic req;          // request pulse, block at base
    logic [15:0] base;  // block base word address
    logic rd;           // device reads a block word
    logic [15:0] raddr; // read word address
    logic [15:0] rdata; // read data, valid next cycle
    logic wr;           // device writes a status word
    logic [7:0] warea;  // status memory area code
    logic [15:0] waddr; // word index in area
    logic [15:0] wdata; // status data
    logic done;         // pulse, request finished, status written only if area legal
    modport device (input req, base, rdata,
                    output rd, raddr, wr, warea, waddr, wdata, done);
    modport host (output req, base, rdata,
                  input rd, raddr, wr, warea, waddr, wdata, done);
endinterface

// ### hdl/len_check.sv
// length check per command number
`timescale 1ns/1ps
module len_check (
    input wire logic [15:0] cmd_in, // command number
    input wire logic [15:0] len_in, // length word
    output logic known_out,         // command supported
    output logic len_ok_out         // length suits command
);
    // decode supported commands and legal lengths
    always_comb begin
        known_out = 1'b1;
        len_ok_out = 1'b0;
        unique case (cmd_in)
            cmd_block_pkg::CMD_OUTPUTS:
                len_ok_out = (len_in == cmd_block_pkg::LEN_OUTPUTS);
            cmd_block_pkg::CMD_DEQUEUE:
                len_ok_out = (len_in == cmd_block_pkg::LEN_DEQUEUE);
            cmd_block_pkg::CMD_SEND:
                len_ok_out = (len_in >= cmd_block_pkg::LEN_SEND_MIN) &&
                    (len_in <= cmd_block_pkg::LEN_SEND_MAX);
            cmd_block_pkg::CMD_REPLY_REQ:
                len_ok_out = (len_in >= cmd_block_pkg::LEN_REPLY_MIN) &&
                    (len_in <= cmd_block_pkg::LEN_REPLY_MAX);
            default: known_out = 1'b0;
        endcase
    end
endmodule

// ### hdl/cmd_interp.sv
// command block interpreter, device end
// How it works
// - block: length, wait, status ptr, timers, data
// - length word counts data words from six
// - host writes zero wait flag
// - status type upper byte kept zero
// - area codes 70,72,8,10,12 select status
// - status offset is zero based
// - host gives byte-aligned offset for bit areas
// - timeout and max time words ignored
// - dispatch on command 8,13,14,15
// - outputs command length 3, one enables
// - lengths: 7, 6..70, 10..78
// - buffer holds 71 words, block offsets 0..70
// - status written at designated location
// - host clears status block first
// - host sends requests one at a time
// - finish then status low word 4
// - request while busy gets status 1
// - unknown command gives upper status 206
`timescale 1ns/1ps
module cmd_interp #(
    parameter int BLOCK_WORDS = cmd_block_pkg::MAX_BLOCK_WORDS
) (
    input wire logic mclk_in,         // clock
    input wire logic reset_in,        // sync reset, high
    input wire logic clk_en_in,       // freezes state when low
    comm_request_if.device link,      // shared memory link
    output logic outputs_en_out,      // bus outputs enabled
    output logic dequeue_out,         // pulse, dequeue datagram
    output logic send_out,            // pulse, send datagram
    output logic reply_req_out,       // pulse, send reply request
    output logic [6:0] data_len_out,  // data words of last command passing the length check
    output logic busy_out             // request in progress
);
    // buffer must hold the largest block, index is 7 bits wide
    if (BLOCK_WORDS < cmd_block_pkg::MAX_BLOCK_WORDS ||
        BLOCK_WORDS > 128) begin : g_bad_words
        $error("BLOCK_WORDS out of range");
    end

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_READ = 3'b001,
        S_EXEC = 3'b010,
        S_ST_LO = 3'b011,
        S_ST_HI = 3'b100
    } state_t;

    typedef struct packed {
        state_t st;
        logic [15:0] base;
        logic [6:0] idx;       // word being requested
        logic [6:0] last;      // last word to read
        logic rd_pend;         // read data arrives this cycle
        logic [6:0] rd_idx;
        logic [15:0] len;
        logic [15:0] waitf;
        logic [15:0] stype;
        logic [15:0] soffs;
        logic [15:0] cmd;
        logic [15:0] outval;
        logic [15:0] st_lo;
        logic [15:0] st_hi;
        logic busy_rej;        // busy reject queued
        logic [15:0] rej_base;
        logic rej_active;      // writing a busy reject
        logic outputs_en;
        logic dequeue;
        logic send;
        logic reply_req;
        logic [6:0] data_len;
        logic rd;
        logic [15:0] raddr;
        logic wr;
        logic [7:0] warea;
        logic [15:0] waddr;
        logic [15:0] wdata;
        logic done;
        logic busy;            // request in progress
    } state_s_t;

    state_s_t q, d;
    logic known, len_ok, area_ok;
    // data block words kept for the datagram path
    logic [15:0] block_mem [BLOCK_WORDS];

    len_check u_len (
        .cmd_in(q.cmd),
        .len_in(q.len),
        .known_out(known),
        .len_ok_out(len_ok)
    );

    // status area decode, low byte only, upper must be zero
    always_comb begin
        area_ok = (q.stype[15:8] == 8'h00) &&
            (q.stype[7:0] == cmd_block_pkg::MEM_DISC_IN ||
             q.stype[7:0] == cmd_block_pkg::MEM_DISC_OUT ||
             q.stype[7:0] == cmd_block_pkg::MEM_REGISTER ||
             q.stype[7:0] == cmd_block_pkg::MEM_ANALOG_IN ||
             q.stype[7:0] == cmd_block_pkg::MEM_ANALOG_OUT);
    end

    // next-state logic
    always_comb begin
        d = q;
        d.rd = 1'b0;
        d.wr = 1'b0;
        d.done = 1'b0;
        d.dequeue = 1'b0;
        d.send = 1'b0;
        d.reply_req = 1'b0;
        d.rd_pend = q.rd;
        d.rd_idx = q.idx;
        if (link.req && q.st != S_IDLE) begin
            d.busy_rej = 1'b1;
            d.rej_base = link.base;
        end
        // capture read data at its block offset
        if (q.rd_pend) begin
            unique case (q.rd_idx)
                cmd_block_pkg::OFF_LEN[6:0]: begin
                    d.len = link.rdata;
                    if (link.rdata > cmd_block_pkg::LEN_REPLY_MAX)
                        d.last = cmd_block_pkg::OFF_LAST[6:0];
                    else
                        d.last = 7'(link.rdata +
                            16'(cmd_block_pkg::OFF_CMD) - 16'h0001);
                end
                cmd_block_pkg::OFF_WAIT[6:0]: d.waitf = link.rdata;
                cmd_block_pkg::OFF_STYPE[6:0]: d.stype = link.rdata;
                cmd_block_pkg::OFF_SOFFS[6:0]: d.soffs = link.rdata;
                cmd_block_pkg::OFF_CMD[6:0]: d.cmd = link.rdata;
                cmd_block_pkg::OFF_OUTVAL[6:0]: d.outval = link.rdata;
                default: ;
            endcase
        end
        unique case (q.st)
            S_IDLE: begin
                if (q.busy_rej) begin
                    d.busy_rej = 1'b0;
                    d.rej_active = 1'b1;
                    d.base = q.rej_base;
                    d.idx = cmd_block_pkg::OFF_LEN[6:0];
                    d.last = cmd_block_pkg::OFF_SOFFS[6:0];
                    d.st = S_READ;
                end else if (link.req) begin
                    d.rej_active = 1'b0;
                    d.base = link.base;
                    d.idx = cmd_block_pkg::OFF_LEN[6:0];
                    d.last = cmd_block_pkg::OFF_CMD[6:0];
                    d.st = S_READ;
                end
            end
            S_READ: begin
                if (!q.rd && !q.rd_pend && q.idx > q.last) begin
                    d.st = S_EXEC;
                end else if (!q.rd && !q.rd_pend) begin
                    d.rd = 1'b1;
                    d.raddr = q.base + 16'(q.idx);
                end else if (q.rd) begin
                    d.idx = q.idx + 7'h01;
                end
            end
            S_EXEC: begin
                d.st_hi = cmd_block_pkg::ST_NONE;
                d.st_lo = cmd_block_pkg::ST_DONE;
                if (q.rej_active) begin
                    d.st_lo = cmd_block_pkg::ST_BUSY;
                end else if (!known) begin
                    d.st_lo = cmd_block_pkg::ST_SYNTAX;
                    d.st_hi = cmd_block_pkg::STX_BAD_CMD;
                end else if (!len_ok) begin
                    d.st_lo = cmd_block_pkg::ST_SYNTAX;
                    d.st_hi = cmd_block_pkg::STX_BAD_LEN;
                end else begin
                    d.data_len = q.len[6:0];
                    unique case (q.cmd)
                        cmd_block_pkg::CMD_OUTPUTS: begin
                            if (q.outval == cmd_block_pkg::OUT_ENABLE)
                                d.outputs_en = 1'b1;
                            else if (q.outval == 16'h0000)
                                d.outputs_en = 1'b0;
                            else
                                d.st_lo = cmd_block_pkg::ST_DATA_ERR;
                        end
                        cmd_block_pkg::CMD_DEQUEUE: d.dequeue = 1'b1;
                        cmd_block_pkg::CMD_SEND: d.send = 1'b1;
                        default: d.reply_req = 1'b1;
                    endcase
                end
                d.st = area_ok ? S_ST_LO : S_IDLE;
                if (!area_ok)
                    d.done = 1'b1; // no legal place for status
            end
            S_ST_LO: begin
                d.wr = 1'b1;
                d.warea = q.stype[7:0];
                d.waddr = q.soffs;
                d.wdata = q.st_lo;
                d.st = S_ST_HI;
            end
            S_ST_HI: begin
                d.wr = 1'b1;
                d.waddr = q.soffs + 16'h0001;
                d.wdata = q.st_hi;
                d.done = 1'b1;
                d.st = S_IDLE;
            end
            default: d.st = S_IDLE;
        endcase
        // single pass: length word sets the last word read, then data up to length
        if (q.st == S_READ && !q.rej_active && q.rd_pend &&
            q.rd_idx == cmd_block_pkg::OFF_LEN[6:0])
            // a zero length still reads the command word
            d.last = (link.rdata > cmd_block_pkg::LEN_REPLY_MAX) ?
                cmd_block_pkg::OFF_LAST[6:0] :
                (link.rdata == '0) ? cmd_block_pkg::OFF_CMD[6:0] :
                7'(link.rdata + 16'(cmd_block_pkg::OFF_CMD) - 16'h0001);
        else if (q.rej_active && q.st == S_READ)
            d.last = cmd_block_pkg::OFF_SOFFS[6:0];
        if (d.last > 7'(BLOCK_WORDS - 1))
            d.last = 7'(BLOCK_WORDS - 1);
        // busy kept in a flop so the output is registered
        d.busy = (d.st != S_IDLE);
    end

    // register state
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            q <= '0;
        end else if (clk_en_in) begin
            q <= d;
        end
    end

    // keep data words in the block buffer
    always_ff @(posedge mclk_in) begin
        if (clk_en_in && q.rd_pend && !q.rej_active)
            block_mem[q.rd_idx] <= link.rdata;
    end

    assign link.rd = q.rd;
    assign link.raddr = q.raddr;
    assign link.wr = q.wr;
    assign link.warea = q.warea;
    assign link.waddr = q.waddr;
    assign link.wdata = q.wdata;
    assign link.done = q.done;
    assign outputs_en_out = q.outputs_en;
    assign dequeue_out = q.dequeue;
    assign send_out = q.send;
    assign reply_req_out = q.reply_req;
    assign data_len_out = q.data_len;
    assign busy_out = q.busy;
endmodule

// ### hdl/cmd_host.sv
// requester end: shared memory holding command block and status
`timescale 1ns/1ps
module cmd_host #(
    parameter int MEM_WORDS = 256
) (
    input wire logic mclk_in,           // clock
    input wire logic reset_in,          // sync reset, high
    input wire logic clk_en_in,         // freezes state when low
    comm_request_if.host link,          // shared memory link
    input wire logic ld_in,             // write a memory word
    input wire logic [7:0] ld_addr_in,  // word address
    input wire logic [15:0] ld_data_in, // word data
    input wire logic go_in,             // start request at base
    input wire logic [7:0] go_base_in,  // command block base
    output logic req_out,               // request in flight
    output logic [15:0] st_lo_out,      // last status low word
    output logic [15:0] st_hi_out,      // last status high word
    output logic [7:0] st_area_out      // area of last status
);
    // memory is addressed by 8 bits
    if (MEM_WORDS != 256) begin : g_bad_mem
        $error("MEM_WORDS must be 256");
    end

    typedef struct packed {
        logic busy;
        logic req;
        logic [15:0] base;
        logic [15:0] rdata;
        logic hi_next;
        logic [15:0] st_lo;
        logic [15:0] st_hi;
        logic [7:0] st_area;
    } host_s_t;

    host_s_t q, d;
    logic [15:0] mem [MEM_WORDS];

    // one request at a time, next only after done
    always_comb begin
        d = q;
        d.req = 1'b0;
        d.rdata = mem[link.raddr[7:0]];
        if (go_in && !q.busy) begin
            d.req = 1'b1;
            d.busy = 1'b1;
            d.base = {8'h00, go_base_in};
        end
        if (link.wr) begin
            d.st_area = link.warea;
            d.hi_next = !q.hi_next;
            if (q.hi_next) d.st_hi = link.wdata;
            else d.st_lo = link.wdata;
        end
        if (link.done) begin
            d.busy = 1'b0;
            d.hi_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            q <= '0;
        end else if (clk_en_in) begin
            q <= d;
        end
    end

    // memory: loads from user, status from device (flat map)
    always_ff @(posedge mclk_in) begin
        if (clk_en_in) begin
            if (link.wr)
                mem[link.waddr[7:0]] <= link.wdata;
            else if (ld_in)
                mem[ld_addr_in] <= ld_data_in;
        end
    end

    assign link.req = q.req;
    assign link.base = q.base;
    assign link.rdata = q.rdata;
    assign req_out = q.busy;
    assign st_lo_out = q.st_lo;
    assign st_hi_out = q.st_hi;
    assign st_area_out = q.st_area;
endmodule

// ### testbench/cmd_block_props.sv
// concurrent checks on the shared-memory request link
`timescale 1ns/1ps
module cmd_block_props (
    input wire logic mclk_in,       // clock
    input wire logic reset_in,      // sync reset, high
    input wire logic req,           // request pulse
    input wire logic [15:0] base,   // block base
    input wire logic rd,            // block word read
    input wire logic [15:0] raddr,  // read address
    input wire logic [15:0] rdata,  // read data
    input wire logic wr,            // status write
    input wire logic [7:0] warea,   // status area code
    input wire logic [15:0] waddr,  // status index
    input wire logic [15:0] wdata,  // status data
    input wire logic done           // status complete
);
    logic [15:0] base_q, soff_q, len_q, cmd_q, ra_q;
    logic rd_q, act_q, known, lok;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // capture header words as they come back from memory
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            {base_q, soff_q, len_q, cmd_q, ra_q} <= '0;
            rd_q <= 1'b0;
            act_q <= 1'b0;
        end else begin
            rd_q <= rd;
            ra_q <= raddr;
            if (req) begin
                base_q <= base;
                act_q <= 1'b1;
            end else if (done) begin
                act_q <= 1'b0;
            end
            if (rd_q && ra_q == base_q) len_q <= rdata;
            if (rd_q && ra_q == base_q + 16'h0003) soff_q <= rdata;
            if (rd_q && ra_q == base_q + 16'h0006) cmd_q <= rdata;
        end
    end
    // length legality per command
    always_comb begin
        known = 1'b1;
        case (cmd_q)
            16'h0008: lok = len_q == 16'h0003;
            16'h000D: lok = len_q == 16'h0007;
            16'h000E: lok = len_q >= 16'h0006 && len_q <= 16'h0046;
            16'h000F: lok = len_q >= 16'h000A && len_q <= 16'h004E;
            default: begin
                known = 1'b0;
                lok = 1'b0;
            end
        endcase
    end
    property p_first_read;
        req |-> ##[1:8] (rd && raddr == base_q);
    endproperty
    a_first_read: assert property (p_first_read)
        else $error("block read does not start at base");
    property p_read_range;
        rd && act_q |-> raddr >= base_q && raddr <= base_q + 16'h0046;
    endproperty
    a_read_range: assert property (p_read_range)
        else $error("block read outside block");
    property p_idle_quiet;
        !act_q && !req |-> !rd && !wr;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("link activity with no request");
    property p_area;
        wr |-> warea inside {8'h46, 8'h48, 8'h08, 8'h0A, 8'h0C};
    endproperty
    a_area: assert property (p_area)
        else $error("status written to bad area");
    property p_offset;
        wr |-> waddr == soff_q || waddr == soff_q + 16'h0001;
    endproperty
    a_offset: assert property (p_offset)
        else $error("status index off");
    property p_hi_done;
        wr && waddr == soff_q + 16'h0001
            |-> done && $past(wr) && $past(waddr) == soff_q;
    endproperty
    a_hi_done: assert property (p_hi_done)
        else $error("status pair out of order");
    property p_done_bound;
        req |-> ##[2:400] done;
    endproperty
    a_done_bound: assert property (p_done_bound)
        else $error("request never completed");
    property p_unknown;
        wr && waddr == soff_q + 16'h0001 && !known |-> wdata == 16'h00CE;
    endproperty
    a_unknown: assert property (p_unknown)
        else $error("unknown command not reported");
    property p_badlen;
        wr && waddr == soff_q && known && !lok |-> wdata == 16'h0008;
    endproperty
    a_badlen: assert property (p_badlen)
        else $error("length mismatch not reported");
    property p_ok;
        wr && waddr == soff_q && lok && cmd_q != 16'h0008
            |-> wdata == 16'h0004;
    endproperty
    a_ok: assert property (p_ok)
        else $error("good request not completed");
endmodule

// ### testbench/tb.sv
// self-checking bench joining requester and interpreter
`timescale 1ns/1ps
module tb;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic ld_in = 1'b0;
    logic [7:0] ld_addr_in = 8'h00;
    logic [15:0] ld_data_in = 16'h0000;
    logic go_in = 1'b0;
    logic [7:0] go_base_in = 8'h00;
    logic req_out, outputs_en_out, dequeue_out, send_out, reply_req_out;
    logic busy_out;
    logic [15:0] st_lo_out, st_hi_out;
    logic [7:0] st_area_out;
    logic [6:0] data_len_out;
    logic en_exp = 1'b0;
    logic clk_en_in = 1'b1;
    logic [6:0] dl_exp = 7'h00;
    int failures = 0;
    int samples_checked = 0;
    int n_deq = 0, n_send = 0, n_rep = 0, i;
    int areas [5] = '{70, 72, 8, 10, 12};
    int cs [16][3] = '{'{8, 3, 1}, '{8, 3, 2}, '{8, 4, 0}, '{8, 3, 0},
        '{13, 7, 0}, '{13, 6, 0}, '{14, 6, 0}, '{14, 70, 0}, '{14, 5, 0},
        '{14, 71, 0}, '{15, 10, 0}, '{15, 78, 0}, '{15, 9, 0},
        '{15, 79, 0}, '{9, 3, 0}, '{16, 7, 0}};
    comm_request_if link();
    cmd_host cmd_host_inst(.mclk_in(mclk_in), .reset_in(reset_in),
        .clk_en_in(clk_en_in), .link(link), .ld_in(ld_in),
        .ld_addr_in(ld_addr_in), .ld_data_in(ld_data_in), .go_in(go_in),
        .go_base_in(go_base_in), .req_out(req_out), .st_lo_out(st_lo_out),
        .st_hi_out(st_hi_out), .st_area_out(st_area_out));
    cmd_interp cmd_interp_inst(.mclk_in(mclk_in), .reset_in(reset_in),
        .clk_en_in(clk_en_in), .link(link),
        .outputs_en_out(outputs_en_out),
        .dequeue_out(dequeue_out), .send_out(send_out),
        .reply_req_out(reply_req_out), .data_len_out(data_len_out),
        .busy_out(busy_out));
    cmd_block_props props_inst(.mclk_in(mclk_in), .reset_in(reset_in),
        .req(link.req), .base(link.base), .rd(link.rd),
        .raddr(link.raddr), .rdata(link.rdata), .wr(link.wr),
        .warea(link.warea), .waddr(link.waddr), .wdata(link.wdata),
        .done(link.done));
    // free-running clock
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end
    // count action pulses
    always @(posedge mclk_in) begin
        if (dequeue_out === 1'b1) n_deq++;
        if (send_out === 1'b1) n_send++;
        if (reply_req_out === 1'b1) n_rep++;
    end
    task test_done;
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // one word into requester memory
    task put(input int a, input int d);
        @(negedge mclk_in);
        ld_in = 1'b1;
        ld_addr_in = 8'(a);
        ld_data_in = 16'(d);
        @(negedge mclk_in);
        ld_in = 1'b0;
    endtask
    // expected status as {high, low}
    function logic [31:0] exp_st(input int c, input int l, input int v);
        logic ok;
        case (c)
            8: ok = l == 3;
            13: ok = l == 7;
            14: ok = l >= 6 && l <= 70;
            15: ok = l >= 10 && l <= 78;
            default: return {16'h00CE, 16'h0008};
        endcase
        if (!ok) return {16'h00CA, 16'h0008};
        if (c == 8 && v > 1) return {16'h0000, 16'h0010};
        return {16'h0000, 16'h0004};
    endfunction
    // build a block, issue it, check the returned status
    task run(input int c, input int l, input int v, input int k);
        int b, off, n, d0, s0, r0;
        logic [31:0] e;
        b = (k % 3) * 30;
        off = 184 + 8 * (k % 8);
        put(b, l);
        put(b + 1, 0);
        put(b + 2, areas[k % 5]);
        put(b + 3, off);
        put(b + 4, 0);
        put(b + 5, 0);
        put(b + 6, c);
        for (n = 7; n <= 70 && n <= l + 5; n++)
            put(b + n, $urandom_range(0, 65535));
        put(b + 8, v);
        put(off, 0);
        put(off + 1, 0);
        {d0, s0, r0} = {n_deq, n_send, n_rep};
        @(negedge mclk_in);
        go_in = 1'b1;
        go_base_in = 8'(b);
        @(negedge mclk_in);
        go_in = 1'b0;
        // freeze both ends a cycle or two: request must wait
        if (k % 3 != 0) begin
            clk_en_in = 1'b0;
            repeat (k % 3) @(negedge mclk_in);
            chk_flag(busy_out, 1'b0);
            clk_en_in = 1'b1;
        end
        n = 0;
        while (req_out !== 1'b0) begin
            @(negedge mclk_in);
            n++;
            if (n > 1000) begin
                failures++;
                $display("ERROR %0t: request hung", $time);
                test_done();
            end
        end
        @(negedge mclk_in);
        e = exp_st(c, l, v);
        chk_word(st_lo_out, e[15:0]);
        chk_word(st_hi_out, e[31:16]);
        chk_word({8'h00, st_area_out}, 16'(areas[k % 5]));
        if (e[15:0] == 16'h0004 && c == 8) en_exp = v[0];
        if (e[31:16] == 16'h0000) dl_exp = 7'(l);
        chk_word({9'h000, data_len_out}, {9'h000, dl_exp});
        chk_flag(busy_out, 1'b0);
        chk_flag(outputs_en_out, en_exp);
        chk_word(16'(n_deq - d0), 16'(e[15:0] == 16'h0004 && c == 13));
        chk_word(16'(n_send - s0), 16'(e[15:0] == 16'h0004 && c == 14));
        chk_word(16'(n_rep - r0), 16'(e[15:0] == 16'h0004 && c == 15));
    endtask
    // main sequence: corner table then random blocks
    initial begin
        void'($urandom(88228));
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in);
        reset_in = 1'b0;
        for (i = 0; i < 16; i++)
            run(cs[i][0], cs[i][1], cs[i][2], i);
        for (i = 16; i < 40; i++)
            run($urandom_range(0, 4) < 4 ? cs[4 * $urandom_range(0, 3)][0]
                : $urandom_range(0, 31), $urandom_range(0, 80),
                $urandom_range(0, 2), i);
        test_done();
    end
endmodule
